/* File: hw/pin_function_select_reset_defs.svh */
/*
 * Constants for the pin function select and reset release block.
 * Assumes inclusion by bare name from hw/.
 */
`ifndef PIN_FUNCTION_SELECT_RESET_DEFS_SVH
`define PIN_FUNCTION_SELECT_RESET_DEFS_SVH

// ****************************************************************
// Reset release timing
// ****************************************************************
`define RST_RELEASE_CYCLES  8'h20
`define RST_CNT_W           8

// ****************************************************************
// Pin indices and reset values
// ****************************************************************
`define PIN_TEST_CLK        0
`define PIN_HW_RESET        1
`define PIN_COUNT           2
`define SEL_PRIMARY         1'h0
`define DIR_INPUT           1'h0

`endif

/* File: hw/pin_function_select_reset_pkg.sv */
/*
 * Types for the pin function select and reset release block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pin_function_select_reset_pkg;

    // ************************************************************
    // Reset release state machine
    // ************************************************************
    typedef enum logic [1:0] {
        RST_HOLD_ST  = 2'b00,
        RST_COUNT_ST = 2'b01,
        RST_RUN_ST   = 2'b10
    } rst_state_type;

endpackage : pin_function_select_reset_pkg

/* File: hw/reset_release_sync.sv */
/*
 * Reset release sequencer: synchronises the merged reset request and
 * releases internal reset after a fixed count of core clocks.
 * Assumes i_rst_req is asynchronous to i_core_clk.
 */
`timescale 1ns/100ps
`include "pin_function_select_reset_defs.svh"

module reset_release_sync
    import pin_function_select_reset_pkg::*;
(
    // Clock and power-on reset
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    // Reset request, any source, active high
    input  wire logic i_rst_req,
    // Internal reset out
    output logic      o_int_rst
);

    logic                   sync1_ff;
    logic                   sync2_ff;
    logic [`RST_CNT_W-1:0]  cnt_ff;
    logic [`RST_CNT_W-1:0]  nxt_cnt;
    rst_state_type          state_ff;
    rst_state_type          nxt_state;
    logic                   int_rst_ff;
    wire logic              cnt_done = (cnt_ff == `RST_RELEASE_CYCLES - 8'h01);

    // ****************************************************************
    // Synchroniser, asserts asynchronously
    // ****************************************************************
    always_ff @(posedge i_core_clk or posedge i_rst or posedge i_rst_req) begin
        if (i_rst || i_rst_req) begin // see RQ6
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
        end else begin // see RQ10
            sync1_ff <= 1'b0;
            sync2_ff <= sync1_ff;
        end
    end

    // Next state of the release counter
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            RST_HOLD_ST: begin
                nxt_cnt = '0;
                if (!sync2_ff) nxt_state = RST_COUNT_ST;
            end
            RST_COUNT_ST: begin
                nxt_cnt = cnt_ff + 8'h01;
                if (cnt_done) nxt_state = RST_RUN_ST; // see RQ7
            end
            RST_RUN_ST: nxt_state = RST_RUN_ST;
            default: nxt_state = RST_HOLD_ST;
        endcase
        if (sync2_ff) begin
            nxt_state = RST_HOLD_ST;
            nxt_cnt   = '0;
        end
    end

    // Counter and synchronous release
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_ff   <= RST_HOLD_ST;
            cnt_ff     <= '0;
            int_rst_ff <= 1'b1;
        end else begin
            state_ff   <= nxt_state;
            cnt_ff     <= nxt_cnt;
            int_rst_ff <= (nxt_state != RST_RUN_ST); // see RQ7
        end
    end

    assign o_int_rst = int_rst_ff;

    // ****************************************************************
    // Checks
    // ****************************************************************
    // Internal reset still held for the first nine clocks after a request ends
    sequence rel_seq;
        o_int_rst [*8] ##1 o_int_rst;
    endsequence

    chk_hold_while_req: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RQ6
        sync2_ff |=> o_int_rst)
        else $error("internal reset released while request held");

    chk_release_late: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RQ7
        $fell(o_int_rst) |-> $past(state_ff) == RST_COUNT_ST && $past(cnt_done))
        else $error("internal reset released before count");

    chk_release_seq: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RQ10
        $fell(sync2_ff) |-> rel_seq)
        else $error("internal reset released too soon after request");

endmodule : reset_release_sync

/* File: hw/pin_function_select_reset.sv */
/*
 * Pin function select for package pins one and two, and hardware
 * reset input handling. Pin one: test clock or port_d_bit2_io.
 * Pin two: active-low hardware reset or port_d_bit4_io.
 * Assumes pin inputs are asynchronous; pin levels are resolved outside.
 */
// Summary of operation
// RQ1 - After reset each pin sits in its primary function.
// RQ2 - Alternative function needs both peripheral-enable and peripheral-select set.
// RQ3 - In I/O mode each pin direction is set on its own.
// RQ4 - Pin one defaults to test clock, not port_d_bit2_io.
// RQ5 - Test clock is a gated debugger clock with internal pull-up.
// RQ6 - Reset pin low keeps the device in reset.
// RQ7 - Internal reset releases synchronously after a fixed clock count.
// RQ8 - Pin two defaults to hardware reset, not port_d_bit4_io.
// RQ9 - In I/O mode, power-on, watchdog and software resets still act.
// RQ10 - Reset pin passes two flip-flops before the release counter.
`timescale 1ns/100ps
`include "pin_function_select_reset_defs.svh"

module pin_function_select_reset
    import pin_function_select_reset_pkg::*;
(
    // Clock and power-on reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    // Software configuration, one bit per pin
    input  wire logic [1:0]  i_periph_en,
    input  wire logic [1:0]  i_periph_sel,
    input  wire logic [1:0]  i_io_dir_out,
    input  wire logic [1:0]  i_io_data_out,
    // Other reset sources
    input  wire logic        i_watchdog_reset,
    input  wire logic        i_sw_reset,
    // Pins
    input  wire logic [1:0]  i_pin,
    output logic      [1:0]  o_pin,
    output logic      [1:0]  o_pin_oe,
    output logic      [1:0]  o_pin_pullup,
    // Function outputs
    output logic      [1:0]  o_io_data_in,
    output logic             o_test_clk,
    output logic             o_int_rst
);

    // Per-pin configuration state
    logic [1:0] sel_ff;
    logic [1:0] dir_ff;
    logic [1:0] dout_ff;
    // Synchronised pin levels, captured data and pull-up enables
    logic [1:0] pin_s1_ff;
    logic [1:0] pin_s2_ff;
    logic [1:0] din_ff;
    logic [1:0] pull_ff;
    // Test clock, reset request and internal reset
    logic       tck_ff;
    logic       rst_req_ff;
    logic       int_rst;

    // Alternative selected only when both controls agree
    function automatic logic [1:0] alt_sel(input logic [1:0] en, input logic [1:0] sel);
        alt_sel = en & sel;
    endfunction : alt_sel

    // Select and reset request decode
    wire logic [1:0] nxt_sel = alt_sel(i_periph_en, i_periph_sel); // see RQ2
    wire logic       pin_reset_active = (sel_ff[`PIN_HW_RESET] == `SEL_PRIMARY)
                                        && !pin_s2_ff[`PIN_HW_RESET]; // see RQ8
    wire logic       nxt_rst_req = pin_reset_active || i_watchdog_reset || i_sw_reset;

    // ****************************************************************
    // Pin input synchronisers
    // ****************************************************************
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            pin_s1_ff <= 2'h3;
            pin_s2_ff <= 2'h3;
        end else begin
            pin_s1_ff <= i_pin;
            pin_s2_ff <= pin_s1_ff; // see RQ10
        end
    end

    // ****************************************************************
    // Function select, per pin
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < `PIN_COUNT; g = g + 1) begin : g_pin
            always_ff @(posedge i_core_clk or posedge i_rst) begin
                if (i_rst) begin
                    sel_ff[g]  <= `SEL_PRIMARY; // see RQ1
                    dir_ff[g]  <= `DIR_INPUT;
                    dout_ff[g] <= 1'h0;
                    din_ff[g]  <= 1'h0;
                    pull_ff[g] <= 1'h1;
                end else if (int_rst) begin
                    // Any device reset returns the pin to its primary function
                    sel_ff[g]  <= `SEL_PRIMARY; // see RQ1, RQ8
                    dir_ff[g]  <= `DIR_INPUT;
                    dout_ff[g] <= 1'h0;
                    din_ff[g]  <= 1'h0;
                    pull_ff[g] <= 1'h1;
                end else begin
                    sel_ff[g]  <= nxt_sel[g]; // see RQ2
                    dir_ff[g]  <= nxt_sel[g] & i_io_dir_out[g]; // see RQ3
                    dout_ff[g] <= i_io_data_out[g];
                    din_ff[g]  <= nxt_sel[g] & pin_s2_ff[g];
                    pull_ff[g] <= ~nxt_sel[g];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Test clock and reset request
    // ****************************************************************
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            tck_ff     <= 1'b1;
            rst_req_ff <= 1'b0;
        end else begin
            tck_ff     <= (sel_ff[`PIN_TEST_CLK] == `SEL_PRIMARY) ?
                          pin_s2_ff[`PIN_TEST_CLK] : 1'b1; // see RQ4
            rst_req_ff <= nxt_rst_req; // see RQ9
        end
    end

    // Synchronised release of the internal reset
    reset_release_sync u_release (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_rst_req  (rst_req_ff),
        .o_int_rst  (int_rst)
    );

    // Outputs, all from flip-flops
    assign o_pin        = dout_ff;
    assign o_pin_oe     = dir_ff;
    assign o_pin_pullup = pull_ff; // see RQ5
    assign o_io_data_in = din_ff;
    assign o_test_clk   = tck_ff; // see RQ5
    assign o_int_rst    = int_rst;

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_primary_after_rst: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RQ1
        int_rst |=> sel_ff == 2'h0)
        else $error("pin not primary after reset");

    chk_alt_needs_both: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RQ2
        $rose(sel_ff[0]) |-> $past(i_periph_en[0] && i_periph_sel[0]))
        else $error("alternative chosen without both controls");

    chk_dir_only_io: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RQ3
        (o_pin_oe & ~sel_ff) == 2'h0)
        else $error("pin driven while in primary function");

    chk_tck_follows: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RQ4
        (sel_ff[0] == 1'b0) |=> o_test_clk == $past(pin_s2_ff[0]))
        else $error("test clock not passed from pin one");

    chk_pullup_tck: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RQ5
        !sel_ff[0] |-> o_pin_pullup[0])
        else $error("test clock pull-up missing");

    chk_reset_pin_low: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RQ6
        pin_reset_active |-> ##[1:4] o_int_rst)
        else $error("reset pin low did not reset");

    chk_reset_pin_io: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RQ8
        sel_ff[1] && !i_watchdog_reset && !i_sw_reset |=> !rst_req_ff)
        else $error("reset pin acted while in I/O mode");

    chk_other_resets: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RQ9
        (i_watchdog_reset || i_sw_reset) |-> ##[1:4] o_int_rst)
        else $error("watchdog or software reset lost");

    // ****************************************************************
    // Reset request path, idle test clock and output data checks
    // ****************************************************************
    // Request flop first, then internal reset one clock later
    sequence req_path_seq;
        rst_req_ff ##1 o_int_rst;
    endsequence

    chk_pin_req_path: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RQ6
        pin_reset_active |=> req_path_seq)
        else $error("reset pin low missed the request path");

    chk_dev_req_path: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RQ9
        (i_watchdog_reset || i_sw_reset) |=> req_path_seq)
        else $error("watchdog or software reset missed the request path");

    chk_tck_idle_io: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RQ4
        sel_ff[0] |=> o_test_clk)
        else $error("test clock moved while pin one in I/O");

    chk_dout_follows: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RQ3
        !$past(int_rst) |-> o_pin == $past(i_io_data_out))
        else $error("output data not taken from its control");

    // ****************************************************************
    // Per-pin checks
    // ****************************************************************
    // Direction, captured data and pull-up of each pin on its own
    generate
        for (g = 0; g < `PIN_COUNT; g = g + 1) begin : g_chk
            chk_dir_per_pin: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RQ3
                sel_ff[g] |-> o_pin_oe[g] == $past(i_io_dir_out[g]))
                else $error("pin direction not taken from its own control");

            chk_din_primary: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RQ1
                !sel_ff[g] |-> !o_io_data_in[g])
                else $error("input data shown while pin in primary function");

            chk_pullup_io: assert property (@(posedge i_core_clk) disable iff (i_rst) // see RQ2
                sel_ff[g] |-> !o_pin_pullup[g])
                else $error("pull-up left on while pin in I/O");
        end
    endgenerate

endmodule : pin_function_select_reset

/* File: verification/board_debug_model.sv */
/*
 * Board reset button and debugger test clock model.
 * Assumes the bench resolves pin levels against the block's drivers.
 */
`timescale 1ns/100ps

module board_debug_model (
    // Clock
    input  wire logic i_core_clk,
    // Bench commands
    input  wire logic i_run_tck,
    input  wire logic i_hold_rst,
    // Pin levels
    output logic      o_tck_lvl,
    output logic      o_rst_n_lvl
);
    // ************************************************************
    // Pin drivers
    // ************************************************************
    logic [1:0] div_ff = 2'h0;

    // Gated clock, stands high between bursts
    always_ff @(posedge i_core_clk) begin
        div_ff <= (div_ff == 2'h2) ? 2'h0 : div_ff + 2'h1;
        if (!i_run_tck) o_tck_lvl <= 1'h1;
        else if (div_ff == 2'h2) o_tck_lvl <= ~o_tck_lvl;
    end

    // Reset button, pulled high when released
    always_ff @(posedge i_core_clk) o_rst_n_lvl <= ~i_hold_rst;
endmodule : board_debug_model

/* File: verification/pin_function_select_reset_tb_top.sv */
/*
 * Self-checking bench for the pin function select block.
 * Assumes the board model and the design files are compiled first.
 */
`timescale 1ns/100ps
`include "pin_function_select_reset_defs.svh"

module pin_function_select_reset_tb_top;
    // ************************************************************
    // Stimulus and checks
    // ************************************************************
    logic            clk = 1'h0, rst = 1'h1, wdog = 1'h0, swr = 1'h0;
    logic            run_tck = 1'h0, hold_rst = 1'h0;
    logic [1:0]      en = 2'h0, sel = 2'h0, dir = 2'h0, dout = 2'h0;
    wire logic [1:0] pin, o_pin, oe, pu, din;
    wire logic       tclk, int_rst, tck_lvl, rst_n_lvl;
    int              miscompares = 0, checks = 0, n;

    // Wire level from both parties
    assign pin = {oe[1] ? o_pin[1] : rst_n_lvl, oe[0] ? o_pin[0] : tck_lvl};

    pin_function_select_reset DUT (.i_core_clk(clk), .i_rst(rst), .i_periph_en(en),
        .i_periph_sel(sel), .i_io_dir_out(dir), .i_io_data_out(dout),
        .i_watchdog_reset(wdog), .i_sw_reset(swr), .i_pin(pin), .o_pin(o_pin),
        .o_pin_oe(oe), .o_pin_pullup(pu), .o_io_data_in(din), .o_test_clk(tclk),
        .o_int_rst(int_rst));
    board_debug_model PARTNER (.i_core_clk(clk), .i_run_tck(run_tck),
        .i_hold_rst(hold_rst), .o_tck_lvl(tck_lvl), .o_rst_n_lvl(rst_n_lvl));

    initial forever #4 clk = ~clk;

    task automatic final_report;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask : chk

    // Wait n edges, then settle to the falling edge
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        @(negedge clk);
    endtask : cyc

    // Expected synced input: own data when driving, board level otherwise
    function automatic logic [1:0] exp_din(input logic [1:0] m, d, o, p);
        return m & ((d & o) | (~d & p));
    endfunction : exp_din

    task automatic release_check;
        n = 0;
        while (int_rst === 1'h1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk("release delay", 2'h1, {1'h0, n >= `RST_RELEASE_CYCLES && n < 60});
        cyc(0);
        chk("pullup after reset", 2'h3, pu);
    endtask : release_check

    task automatic cfg(input logic [1:0] e, s, d, o);
        @(posedge clk);
        {en, sel, dir, dout} <= {e, s, d, o};
        cyc(4);
        chk("oe", e & s & d, oe);
        chk("pullup", ~(e & s), pu);
        chk("pin out", e & s & d & o, o_pin & oe);
        chk("data in", exp_din(e & s, d, o, 2'h3), din);
    endtask : cfg

    task automatic tck_count(output int c);
        logic last;
        c = 0;
        last = tclk;
        repeat (60) begin
            @(negedge clk);
            if (tclk === 1'h1 && last === 1'h0) c++;
            last = tclk;
        end
    endtask : tck_count

    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        final_report();
    end

    // Main sequence
    initial begin
        void'($urandom(28));
        cyc(1);
        chk("reset outputs", 2'h3, {int_rst, oe == 2'h0});
        @(posedge clk);
        rst <= 1'h0;
        release_check();
        $display("test power-on done");
        cfg(2'h1, 2'h2, 2'h3, 2'h3);
        repeat (40) cfg(2'($urandom), 2'($urandom), 2'($urandom), {1'h1, 1'($urandom)});
        $display("test random config done");
        cfg(2'h0, 2'h0, 2'h0, 2'h2);
        run_tck <= 1'h1;
        tck_count(n);
        chk("tck follows", 2'h1, {1'h0, n >= 8});
        // Clock stands high while pin one is moved to I/O
        run_tck <= 1'h0;
        cfg(2'h1, 2'h1, 2'h0, 2'h2);
        run_tck <= 1'h1;
        tck_count(n);
        chk("tck in io", 2'h3, {tclk, n == 0});
        run_tck <= 1'h0;
        $display("test test clock done");
        cfg(2'h1, 2'h1, 2'h1, 2'h3);
        hold_rst <= 1'h1;
        cyc(6);
        chk("pin reset", 2'h3, {int_rst, oe == 2'h0});
        // Device reset also clears the software configuration
        @(posedge clk);
        {hold_rst, en, sel} <= 5'h0;
        release_check();
        $display("test pin reset done");
        for (int k = 0; k < 2; k++) begin
            cfg(2'h2, 2'h2, 2'h0, 2'h2);
            hold_rst <= 1'h1;
            cyc(6);
            chk("io pin low", 2'h0, {int_rst, din[1]});
            hold_rst <= 1'h0;
            cyc(4);
            @(posedge clk);
            {wdog, swr} <= (k == 0) ? 2'h2 : 2'h1;
            cyc(4);
            chk("other reset", 2'h3, {int_rst, pu[1]});
            @(posedge clk);
            {wdog, swr, en, sel} <= 6'h0;
            release_check();
        end
        $display("test other resets done");
        final_report();
    end
endmodule : pin_function_select_reset_tb_top
